// ---- include/tcb_pkg.sv ----
package tcb_pkg;

	// ------------------------------------------------------------
	// Register locations on the 8-bit processor data bus.
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W        = 8;
	localparam int unsigned DATA_W        = 8;
	localparam logic [7:0]  ADDR_CTRL_A   = 8'h00;
	localparam logic [7:0]  ADDR_CTRL_B   = 8'h01;
	localparam logic [7:0]  ADDR_FLAG     = 8'h02;
	localparam logic [7:0]  ADDR_MASK     = 8'h03;
	localparam logic [7:0]  ADDR_CNT_LO   = 8'h04;
	localparam logic [7:0]  ADDR_CNT_HI   = 8'h05;
	localparam logic [7:0]  ADDR_CAP_LO   = 8'h06;
	localparam logic [7:0]  ADDR_CAP_HI   = 8'h07;
	localparam logic [7:0]  ADDR_CMPA_LO  = 8'h08;
	localparam logic [7:0]  ADDR_CMPA_HI  = 8'h09;
	localparam logic [7:0]  ADDR_CMPB_LO  = 8'h0a;
	localparam logic [7:0]  ADDR_CMPB_HI  = 8'h0b;

	// ------------------------------------------------------------
	// Field positions and reset values.
	// ------------------------------------------------------------
	localparam int unsigned WGM_A_LSB     = 0;
	localparam int unsigned WGM_B_LSB     = 3;
	localparam int unsigned CS_LSB        = 0;
	localparam int unsigned OVF_BIT       = 0;
	localparam logic [7:0]  CTRL_RST      = 8'h00;
	localparam logic [7:0]  BYTE_RST      = 8'h00;
	localparam logic [15:0] WORD_RST      = 16'h0000;

	// ------------------------------------------------------------
	// Count limits.
	// ------------------------------------------------------------
	localparam logic [15:0] BOTTOM_VAL    = 16'h0000;
	localparam logic [15:0] MAX_VAL       = 16'hffff;
	localparam logic [15:0] TOP8_VAL      = 16'h00ff;
	localparam logic [15:0] TOP9_VAL      = 16'h01ff;
	localparam logic [15:0] TOP10_VAL     = 16'h03ff;

	// ------------------------------------------------------------
	// Clock source codes and prescaler taps.
	// ------------------------------------------------------------
	localparam int unsigned PRE_W         = 10;
	localparam logic [2:0]  CS_STOP       = 3'h0;
	localparam logic [2:0]  CS_DIV1       = 3'h1;
	localparam logic [2:0]  CS_DIV8       = 3'h2;
	localparam logic [2:0]  CS_DIV64      = 3'h3;
	localparam logic [2:0]  CS_DIV256     = 3'h4;
	localparam logic [2:0]  CS_DIV1024    = 3'h5;
	localparam logic [2:0]  CS_EXT_FALL   = 3'h6;
	localparam logic [9:0]  PRE_DIV8_M    = 10'h007;
	localparam logic [9:0]  PRE_DIV64_M   = 10'h03f;
	localparam logic [9:0]  PRE_DIV256_M  = 10'h0ff;
	localparam logic [9:0]  PRE_DIV1024_M = 10'h3ff;
	localparam logic [9:0]  PRE_RST       = 10'h000;

	typedef enum logic [2:0] {TOP_MAX, TOP_8, TOP_9, TOP_10, TOP_CMPA, TOP_CAP} tcb_top_type;
	typedef enum logic {DIR_UP, DIR_DOWN} tcb_dir_type;

	// Which limit ends the count sequence in each waveform mode.
	function automatic tcb_top_type wgm_top(input logic [3:0] m);
		case (m)
			4'h1, 4'h5:               wgm_top = TOP_8;
			4'h2, 4'h6:               wgm_top = TOP_9;
			4'h3, 4'h7:               wgm_top = TOP_10;
			4'h4, 4'h9, 4'hb, 4'hf:   wgm_top = TOP_CMPA;
			4'h8, 4'ha, 4'hc, 4'he:   wgm_top = TOP_CAP;
			default:                  wgm_top = TOP_MAX;
		endcase
	endfunction

	// Modes that count up to the limit and back down to zero.
	function automatic logic wgm_updown(input logic [3:0] m);
		return m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb};
	endfunction

endpackage

// ---- include/tcb_tick_if.sv ----
`timescale 1ns/1ps

interface tcb_tick_if;
	logic [2:0] sel;
	logic       tick;

	modport core (output sel, input tick);
	modport gen  (input sel, output tick);
endinterface

// ---- logic/tcb_clksel.sv ----
`timescale 1ns/1ps

module tcb_clksel
	import tcb_pkg::*;
(
	input  wire logic  core_clk,
	input  wire logic  rstn,
	input  wire logic  ext_clk_pin,
	tcb_tick_if.gen    tif
);

	// ------------------------------------------------------------
	// Pin synchroniser and edge detection.
	// ------------------------------------------------------------
	logic             pin_meta;
	logic             pin_sync;
	logic             pin_last;
	logic [PRE_W-1:0] pre_cnt;
	logic             next_tick;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_last <= 1'b0;
		end else begin
			pin_meta <= ext_clk_pin;
			pin_sync <= pin_meta;
			pin_last <= pin_sync;
		end
	end

	wire rise_seen = pin_sync && !pin_last;
	wire fall_seen = !pin_sync && pin_last;

	// ------------------------------------------------------------
	// Prescaler and source selection.
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			pre_cnt <= PRE_RST;
		else
			pre_cnt <= pre_cnt + 1'b1;
	end

	always_comb begin
		case (tif.sel)
			CS_STOP:     next_tick = 1'b0;
			CS_DIV1:     next_tick = 1'b1;
			CS_DIV8:     next_tick = (pre_cnt & PRE_DIV8_M) == PRE_DIV8_M;
			CS_DIV64:    next_tick = (pre_cnt & PRE_DIV64_M) == PRE_DIV64_M;
			CS_DIV256:   next_tick = (pre_cnt & PRE_DIV256_M) == PRE_DIV256_M;
			CS_DIV1024:  next_tick = (pre_cnt & PRE_DIV1024_M) == PRE_DIV1024_M;
			CS_EXT_FALL: next_tick = fall_seen;
			default:     next_tick = rise_seen;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			tif.tick <= 1'b0;
		else
			tif.tick <= next_tick && (tif.sel != CS_STOP);
	end

endmodule // tcb_clksel

// ---- logic/tcb_counter.sv ----
`timescale 1ns/1ps

// Overview of operation
// - The 16-bit up/down count appears as separate upper and lower byte locations.
// - Every upper-byte write, and every count or capture upper-byte read, touches only the shared holding latch.
// - A lower-byte read copies the count's upper byte into the latch that cycle.
// - A lower-byte write loads latch and written byte into the count together.
// - One latch serves all 16-bit registers, so interleaved accesses corrupt each other.
// - The latch keeps its value after a lower-byte write, allowing reuse.
// - The three-bit source field picks an internal divided or external pin tick.
// - Source field zero stops ticks and the count holds.
// - The count is readable and writable whether ticks run or not.
// - A processor write to the count beats any same-cycle clear or step.
// - Each tick clears, increments or decrements the count per mode and direction.
// - The four-bit waveform mode, split over both control registers, picks the sequence.
// - Ceiling indication at the sequence limit, floor indication at zero.
// - Overflow flag sets at a mode-dependent point and can request an interrupt.
// - Compare register reads return both bytes directly, leaving the latch alone.
// - The floor is 0x0000 and the maximum is 0xffff.

module tcb_counter
	import tcb_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] bus_addr,
	input  wire logic              bus_wr,
	input  wire logic              bus_rd,
	input  wire logic [DATA_W-1:0] bus_wdata,
	output logic      [DATA_W-1:0] bus_rdata,
	input  wire logic              ext_clk_pin,
	output logic                   top_ind,
	output logic                   bottom_ind,
	output logic                   ovf_irq
);

	// ------------------------------------------------------------
	// State.
	// ------------------------------------------------------------
	logic [15:0]  timer_count;
	logic [7:0]   hold_latch;
	logic [15:0]  capture_value_reg;
	logic [15:0]  compare_a;
	logic [15:0]  compare_b;
	logic [7:0]   timer_control_a;
	logic [7:0]   timer_control_b;
	logic         overflow_flag;
	logic         ovf_enable;
	tcb_dir_type  dir;

	tcb_tick_if tif ();

	tcb_clksel u_clksel (
		.core_clk    (core_clk),
		.rstn        (rstn),
		.ext_clk_pin (ext_clk_pin),
		.tif         (tif)
	);

	// ------------------------------------------------------------
	// Address decode.
	// ------------------------------------------------------------
	wire wr_cnt_lo  = bus_wr && bus_addr == ADDR_CNT_LO;
	wire wr_cap_lo  = bus_wr && bus_addr == ADDR_CAP_LO;
	wire wr_cmpa_lo = bus_wr && bus_addr == ADDR_CMPA_LO;
	wire wr_cmpb_lo = bus_wr && bus_addr == ADDR_CMPB_LO;
	wire wr_ctrl_a  = bus_wr && bus_addr == ADDR_CTRL_A;
	wire wr_ctrl_b  = bus_wr && bus_addr == ADDR_CTRL_B;
	wire wr_flag    = bus_wr && bus_addr == ADDR_FLAG;
	wire wr_mask    = bus_wr && bus_addr == ADDR_MASK;
	wire wr_hi      = bus_wr && (bus_addr == ADDR_CNT_HI || bus_addr == ADDR_CAP_HI ||
	                             bus_addr == ADDR_CMPA_HI || bus_addr == ADDR_CMPB_HI);
	wire rd_cnt_lo  = bus_rd && bus_addr == ADDR_CNT_LO;
	wire rd_cap_lo  = bus_rd && bus_addr == ADDR_CAP_LO;

	// ------------------------------------------------------------
	// Mode decode and limits.
	// ------------------------------------------------------------
	wire [3:0] waveform_mode_field = {timer_control_b[WGM_B_LSB +: 2],
	                                  timer_control_a[WGM_A_LSB +: 2]};
	wire tcb_top_type top_sel = wgm_top(waveform_mode_field);
	wire updown  = wgm_updown(waveform_mode_field);

	assign tif.sel = timer_control_b[CS_LSB +: 3];

	wire [15:0] top_val = (top_sel == TOP_8)    ? TOP8_VAL :
	                      (top_sel == TOP_9)    ? TOP9_VAL :
	                      (top_sel == TOP_10)   ? TOP10_VAL :
	                      (top_sel == TOP_CMPA) ? compare_a :
	                      (top_sel == TOP_CAP)  ? capture_value_reg : MAX_VAL;
	wire at_top    = timer_count == top_val;
	wire at_bottom = timer_count == BOTTOM_VAL;

	// ------------------------------------------------------------
	// Counting.
	// ------------------------------------------------------------
	wire step = tif.tick;
	wire up_clear  = !updown && at_top;
	wire turn_down = updown && dir == DIR_UP && at_top;
	wire turn_up   = updown && dir == DIR_DOWN && at_bottom;
	wire go_down   = updown && ((dir == DIR_DOWN && !at_bottom) || turn_down);

	wire [15:0] count_step = up_clear ? BOTTOM_VAL :
	                         go_down  ? timer_count - 16'h0001 :
	                                    timer_count + 16'h0001;
	wire [15:0] next_count = wr_cnt_lo ? {hold_latch, bus_wdata} :
	                         step      ? count_step : timer_count;
	wire tcb_dir_type next_dir = tcb_dir_type'(!updown   ? DIR_UP :
	                             !step || wr_cnt_lo ? dir :
	                             turn_down ? DIR_DOWN :
	                             turn_up   ? DIR_UP : dir);
	wire ovf_event = step && !wr_cnt_lo && (up_clear || turn_up);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			timer_count <= WORD_RST;
			dir         <= DIR_UP;
		end else begin
			timer_count <= next_count;
			dir         <= next_dir;
		end
	end

	// ------------------------------------------------------------
	// Shared holding latch and 16-bit registers.
	// ------------------------------------------------------------
	wire [7:0] next_latch = wr_hi     ? bus_wdata :
	                        rd_cnt_lo ? timer_count[15:8] :
	                        rd_cap_lo ? capture_value_reg[15:8] :
	                                    hold_latch;
	wire [15:0] latched_word = {hold_latch, bus_wdata};

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			hold_latch <= BYTE_RST;
		else
			hold_latch <= next_latch;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			capture_value_reg <= WORD_RST;
			compare_a         <= WORD_RST;
			compare_b         <= WORD_RST;
		end else begin
			if (wr_cap_lo)
				capture_value_reg <= latched_word;
			if (wr_cmpa_lo)
				compare_a <= latched_word;
			if (wr_cmpb_lo)
				compare_b <= latched_word;
		end
	end

	// ------------------------------------------------------------
	// Control, flag and mask.
	// ------------------------------------------------------------
	wire next_flag = ovf_event ||
	                 (overflow_flag && !(wr_flag && bus_wdata[OVF_BIT]));
	wire next_mask = wr_mask ? bus_wdata[OVF_BIT] : ovf_enable;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			timer_control_a <= CTRL_RST;
			timer_control_b <= CTRL_RST;
			overflow_flag   <= 1'b0;
			ovf_enable      <= 1'b0;
		end else begin
			if (wr_ctrl_a)
				timer_control_a <= bus_wdata;
			if (wr_ctrl_b)
				timer_control_b <= bus_wdata;
			overflow_flag <= next_flag;
			ovf_enable    <= next_mask;
		end
	end

	// ------------------------------------------------------------
	// Read data and indications.
	// ------------------------------------------------------------
	wire [7:0] rd_mux =
		(bus_addr == ADDR_CTRL_A)  ? timer_control_a :
		(bus_addr == ADDR_CTRL_B)  ? timer_control_b :
		(bus_addr == ADDR_FLAG)    ? {7'h00, overflow_flag} :
		(bus_addr == ADDR_MASK)    ? {7'h00, ovf_enable} :
		(bus_addr == ADDR_CNT_LO)  ? timer_count[7:0] :
		(bus_addr == ADDR_CAP_LO)  ? capture_value_reg[7:0] :
		(bus_addr == ADDR_CMPA_LO) ? compare_a[7:0] :
		(bus_addr == ADDR_CMPA_HI) ? compare_a[15:8] :
		(bus_addr == ADDR_CMPB_LO) ? compare_b[7:0] :
		(bus_addr == ADDR_CMPB_HI) ? compare_b[15:8] :
		(bus_addr == ADDR_CNT_HI || bus_addr == ADDR_CAP_HI) ? hold_latch :
		8'h00;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bus_rdata  <= BYTE_RST;
			top_ind    <= 1'b0;
			bottom_ind <= 1'b1;
			ovf_irq    <= 1'b0;
		end else begin
			if (bus_rd)
				bus_rdata <= rd_mux;
			top_ind    <= next_count == top_val;
			bottom_ind <= next_count == BOTTOM_VAL;
			ovf_irq    <= next_flag && next_mask;
		end
	end

	// ------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence s_hi_write;
		bus_wr && bus_addr == ADDR_CNT_HI;
	endsequence

	sequence s_lo_write;
		wr_cnt_lo;
	endsequence

	sequence s_idle;
		!bus_wr && !bus_rd;
	endsequence

	AST_FULL_WRITE: assert property (s_hi_write ##1 s_idle ##1 s_lo_write |=>
		timer_count == {$past(bus_wdata, 3), $past(bus_wdata)})
		else $error("Two-byte count write did not land whole.");

	AST_WRITE_WINS: assert property (wr_cnt_lo && tif.tick |=>
		timer_count == $past(latched_word))
		else $error("Count step overrode a processor write.");

	AST_LO_READ_SNAP: assert property (rd_cnt_lo |=>
		hold_latch == $past(timer_count[15:8]))
		else $error("Lower-byte read did not snapshot upper byte.");

	AST_HI_READ_LATCH: assert property (bus_rd && bus_addr == ADDR_CNT_HI |=>
		bus_rdata == $past(hold_latch))
		else $error("Upper-byte read bypassed the latch.");

	AST_LATCH_KEPT: assert property (wr_cnt_lo ##1 s_idle ##1 wr_cmpb_lo |=>
		compare_b[15:8] == $past(hold_latch, 3))
		else $error("Latch changed after a lower-byte write.");

	AST_SHARED: assert property (bus_wr && bus_addr == ADDR_CMPA_HI ##1 s_idle ##1 s_lo_write |=>
		timer_count[15:8] == $past(bus_wdata, 3))
		else $error("Upper-byte writes do not share one latch.");

	AST_CMP_READ: assert property (bus_rd && bus_addr == ADDR_CMPA_HI |=>
		bus_rdata == $past(compare_a[15:8]) && hold_latch == $past(hold_latch))
		else $error("Compare read touched the latch.");

	AST_STOPPED: assert property (tif.sel == CS_STOP && !bus_wr [*2] |=>
		timer_count == $past(timer_count))
		else $error("Count moved with no source selected.");

	AST_UP_STEP: assert property (tif.tick && !wr_cnt_lo && !updown && !at_top |=>
		timer_count == $past(timer_count) + 16'h0001)
		else $error("Up count did not advance by one.");

	AST_OVF: assert property (ovf_event |=> overflow_flag && ovf_irq == ovf_enable)
		else $error("Overflow did not set flag.");

	AST_FLOOR: assert property (bottom_ind == (timer_count == BOTTOM_VAL))
		else $error("Floor indication disagrees with count.");

	AST_TOP_IND: assert property (top_ind == (timer_count == $past(top_val)))
		else $error("Ceiling indication disagrees with count.");

	AST_CLEAR_AT_TOP: assert property (step && !wr_cnt_lo && !updown && at_top |=>
		timer_count == BOTTOM_VAL)
		else $error("Up count did not clear at its limit.");

	AST_TURN_DOWN: assert property (
		step && !wr_cnt_lo && updown && at_top && !at_bottom |=>
		timer_count == $past(timer_count) - 16'h0001)
		else $error("Up-down count did not turn down at its limit.");

	AST_TICK_STOP: assert property (tif.sel == CS_STOP |=> !tif.tick)
		else $error("Tick produced with no source selected.");

	AST_DIV1_TICK: assert property (tif.sel == CS_DIV1 |=> tif.tick)
		else $error("Undivided source gave no tick.");

	AST_HOLD_NO_TICK: assert property (!step && !bus_wr |=> timer_count == $past(timer_count))
		else $error("Count moved without a tick or a write.");

	AST_LATCH_IDLE: assert property (s_idle |=> hold_latch == $past(hold_latch))
		else $error("Latch changed with no access.");

	AST_FLAG_CLEAR: assert property (wr_flag && bus_wdata[OVF_BIT] && !ovf_event |=>
		!overflow_flag)
		else $error("Overflow flag did not clear.");

	AST_IRQ: assert property (ovf_irq == (overflow_flag && ovf_enable))
		else $error("Overflow request disagrees with flag and enable.");

endmodule // tcb_counter

// ---- verification/tcb_cpu_model.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// Processor side of the byte bus.
// ------------------------------------------------------------
module tcb_cpu_model
	import tcb_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic [DATA_W-1:0] bus_rdata,
	output logic      [ADDR_W-1:0] bus_addr,
	output logic                   bus_wr,
	output logic                   bus_rd,
	output logic      [DATA_W-1:0] bus_wdata
);
	initial begin
		bus_addr  = 8'h00;
		bus_wr    = 1'b0;
		bus_rd    = 1'b0;
		bus_wdata = 8'h00;
	end

	// One byte transfer, held through the sampling edge; idle lines show inverted junk.
	task automatic cycle(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(posedge core_clk);
		#1;
		bus_addr  = a;
		bus_wdata = w ? d : ~bus_wdata;
		bus_wr    = w;
		bus_rd    = !w;
		@(posedge core_clk);
		#1;
		q         = bus_rdata;
		bus_wr    = 1'b0;
		bus_rd    = 1'b0;
		bus_addr  = ~a;
		bus_wdata = ~bus_wdata;
	endtask

	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		cycle(1'b1, a, d, q);
	endtask

	task automatic rd8(input logic [7:0] a, output logic [7:0] q);
		cycle(1'b0, a, 8'h00, q);
	endtask

	// Callers run one at a time, so no other access splits a wr16 or rd16 pair.
	// Running counts are written in plain up-count mode, and in up-down mode 1 with the pin source selected.
	task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
		wr8(lo + 8'h01, v[15:8]);
		wr8(lo, v[7:0]);
	endtask

	task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
		rd8(lo, v[7:0]);
		rd8(lo + 8'h01, v[15:8]);
	endtask
endmodule // tcb_cpu_model

// ---- verification/tcb_counter_bench.sv ----
`timescale 1ns/1ps

module tcb_counter_bench
	import tcb_pkg::*;
;
	logic              core_clk;
	logic              rstn;
	logic [ADDR_W-1:0] bus_addr;
	logic              bus_wr;
	logic              bus_rd;
	logic [DATA_W-1:0] bus_wdata;
	logic [DATA_W-1:0] bus_rdata;
	logic              ext_clk_pin;
	logic              top_ind;
	logic              bottom_ind;
	logic              ovf_irq;
	int                err_count;
	int                total_checks;
	logic [15:0]       lims [16] = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff,
					16'h7756, 16'h00ff, 16'h01ff, 16'h03ff,
					16'h2468, 16'h7756, 16'h2468, 16'h7756,
					16'h2468, 16'hffff, 16'h2468, 16'h7756};
	int                divs [5] = '{1, 8, 64, 256, 1024};

	tcb_counter u_dut (.core_clk(core_clk), .rstn(rstn), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.ext_clk_pin(ext_clk_pin), .top_ind(top_ind), .bottom_ind(bottom_ind),
		.ovf_irq(ovf_irq));

	tcb_cpu_model u_cpu (.core_clk(core_clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata));

	// ------------------------------------------------------------
	// Clock, watchdog and reporting.
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial begin
		#400000;
		err_count++;
		tally_and_finish();
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic set_mode(input logic [3:0] m, input logic [2:0] cs);
		u_cpu.wr8(ADDR_CTRL_A, {6'h00, m[1:0]});
		u_cpu.wr8(ADDR_CTRL_B, {3'h0, m[3:2], cs});
	endtask

	task automatic pin(input logic v);
		@(posedge core_clk);
		#1;
		ext_clk_pin = v;
		repeat (8) @(posedge core_clk);
	endtask

	task automatic ind(input logic sig, input logic exp);
		repeat (3) @(posedge core_clk);
		#1;
		chk({15'h0000, sig}, {15'h0000, exp});
	endtask

	// ------------------------------------------------------------
	// Test sequence.
	// ------------------------------------------------------------
	initial begin
		logic [15:0] v;
		logic [7:0]  b;
		logic [7:0]  h;
		int          e;
		err_count    = 0;
		total_checks = 0;
		ext_clk_pin  = 1'b0;
		rstn         = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		chk({15'h0000, bottom_ind}, 16'h0001);
		u_cpu.rd16(ADDR_CNT_LO, v);
		chk(v, WORD_RST);
		u_cpu.rd8(ADDR_CTRL_B, b);
		chk({8'h00, b}, {8'h00, CTRL_RST});
		u_cpu.wr16(ADDR_CNT_LO, 16'h01ff);
		repeat (20) @(posedge core_clk);
		u_cpu.rd16(ADDR_CNT_LO, v);
		chk(v, 16'h01ff);
		// Latch sharing, reuse and the direct compare path.
		u_cpu.wr16(ADDR_CNT_LO, 16'h1234);
		u_cpu.wr8(ADDR_CMPB_LO, 8'h78);
		u_cpu.wr16(ADDR_CMPA_LO, 16'h7756);
		u_cpu.rd8(ADDR_CNT_LO, b);
		chk({8'h00, b}, 16'h0034);
		u_cpu.rd8(ADDR_CMPA_HI, b);
		chk({8'h00, b}, 16'h0077);
		u_cpu.rd8(ADDR_CNT_HI, b);
		chk({8'h00, b}, 16'h0012);
		u_cpu.rd16(ADDR_CMPB_LO, v);
		chk(v, 16'h1278);
		u_cpu.rd8(ADDR_CNT_LO, b);
		u_cpu.rd8(ADDR_CAP_LO, b);
		u_cpu.rd8(ADDR_CNT_HI, b);
		chk({8'h00, b}, 16'h0000);
		u_cpu.wr8(ADDR_CNT_HI, 8'h55);
		u_cpu.rd8(ADDR_CNT_HI, b);
		chk({8'h00, b}, 16'h0055);
		u_cpu.rd16(ADDR_CNT_LO, v);
		chk(v, 16'h1234);
		u_cpu.wr8(ADDR_CMPA_HI, 8'h3c);
		u_cpu.wr8(ADDR_CNT_LO, 8'h21);
		u_cpu.rd16(ADDR_CNT_LO, v);
		chk(v, 16'h3c21);
		u_cpu.wr16(ADDR_CAP_LO, 16'h2468);
		u_cpu.rd16(ADDR_CAP_LO, v);
		chk(v, 16'h2468);
		// Sequence limit of each mode, reached by writes while stopped.
		for (int m = 0; m < 16; m++) begin
			set_mode(m[3:0], CS_STOP);
			u_cpu.wr16(ADDR_CNT_LO, lims[m]);
			ind(top_ind, 1'b1);
			u_cpu.wr16(ADDR_CNT_LO, lims[m] - 16'h0001);
			ind(top_ind, 1'b0);
		end
		u_cpu.wr16(ADDR_CNT_LO, BOTTOM_VAL);
		ind(bottom_ind, 1'b1);
		// Pin-driven ticks on both edge choices.
		set_mode(4'h0, 3'h7);
		u_cpu.wr16(ADDR_CNT_LO, 16'h4000);
		pin(1'b1);
		pin(1'b0);
		u_cpu.rd16(ADDR_CNT_LO, v);
		chk(v, 16'h4001);
		set_mode(4'h0, CS_EXT_FALL);
		pin(1'b1);
		pin(1'b0);
		u_cpu.rd16(ADDR_CNT_LO, v);
		chk(v, 16'h4002);
		// Up-down mode turns round at its limit.
		set_mode(4'h1, 3'h7);
		u_cpu.wr16(ADDR_CNT_LO, 16'h00fe);
		pin(1'b1);
		u_cpu.rd16(ADDR_CNT_LO, v);
		chk(v, 16'h00ff);
		pin(1'b0);
		pin(1'b1);
		u_cpu.rd16(ADDR_CNT_LO, v);
		chk(v, 16'h00fe);
		// A write into a running count lands in place of the step.
		set_mode(4'h0, CS_DIV1);
		u_cpu.wr16(ADDR_CNT_LO, 16'h4000);
		u_cpu.rd8(ADDR_CNT_LO, b);
		u_cpu.rd8(ADDR_CNT_HI, h);
		chk({h, 7'h00, b < 8'h10}, 16'h4001);
		// Each internal rate over a fixed span.
		for (int i = 0; i < 5; i++) begin
			set_mode(4'h0, CS_STOP);
			u_cpu.wr16(ADDR_CNT_LO, 16'h0000);
			u_cpu.wr8(ADDR_CTRL_B, {5'h00, CS_DIV1 + i[2:0]});
			repeat (2048) @(posedge core_clk);
			u_cpu.wr8(ADDR_CTRL_B, CTRL_RST);
			u_cpu.rd16(ADDR_CNT_LO, v);
			e = 2048 / divs[i];
			chk({15'h0000, (int'(v) >= e - 1) && (int'(v) <= e + 4)}, 16'h0001);
		end
		// Overflow on the wrap of a normal count.
		u_cpu.wr8(ADDR_MASK, 8'h01);
		u_cpu.wr8(ADDR_FLAG, 8'h01);
		u_cpu.wr16(ADDR_CNT_LO, 16'hfff0);
		u_cpu.wr8(ADDR_CTRL_B, {5'h00, CS_DIV1});
		for (int i = 0; i < 100 && ovf_irq !== 1'b1; i++)
			@(posedge core_clk);
		#1;
		chk({15'h0000, ovf_irq}, 16'h0001);
		u_cpu.wr8(ADDR_CTRL_B, CTRL_RST);
		u_cpu.rd8(ADDR_FLAG, b);
		chk({8'h00, b}, 16'h0001);
		u_cpu.rd16(ADDR_CNT_LO, v);
		chk({v[15:8], 8'h00}, 16'h0000);
		u_cpu.wr8(ADDR_FLAG, 8'h01);
		ind(ovf_irq, 1'b0);
		tally_and_finish();
	end
endmodule // tcb_counter_bench
